// [core/wdt_pkg.sv]
// constants for the windowed watchdog timer
package wdt_pkg;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  MODE_OFS    = 8'h04;
    localparam logic [7:0]  STATUS_OFS  = 8'h08;
    localparam logic [7:0]  MASK_OFS    = 8'h0C;

    localparam int          CNT_W       = 12;
    localparam int          RELOAD_LSB  = 0;
    localparam int          FIRQ_BIT    = 12;
    localparam int          FRST_BIT    = 13;
    localparam int          PROC_BIT    = 14;
    localparam int          OFF_BIT     = 15;
    localparam int          WIN_LSB     = 16;
    localparam int          DBGH_BIT    = 28;
    localparam int          IDLEH_BIT   = 29;

    localparam logic [31:0] MODE_RST    = 32'h3FFF_2FFF;
    localparam logic [31:0] MODE_WMASK  = 32'h3FFF_FFFF;
    localparam logic [11:0] CNT_RST     = 12'hFFF;

    localparam int          KEY_LSB     = 24;
    localparam logic [7:0]  KEY_VAL     = 8'hA5;
    localparam int          RESTART_BIT = 0;

    localparam int          ST_UNF      = 0;
    localparam int          ST_ERR      = 1;
    localparam logic [1:0]  MASK_RST    = 2'h3;

    localparam int          PRESCALE    = 128;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : wdt_pkg

// [core/windowed_watchdog_timer.sv]
// windowed watchdog timer with an axi4-lite register slave
//
// Summary of operation
// - twelve bit down counter loaded from the programmed reload value
// - counter decrements once per slow clock divided by 128
// - after reset reload is all ones, watchdog runs, fault reset enabled
// - mode register accepts one write; reset alone clears the lock
// - mode write reloads counter with the new parameters and restarts
// - valid restart reloads counter and restarts the prescaler at once
// - control writes without the correct key are ignored
// - underflow sets its flag; fault only with fault reset enabled
// - restart above the window flags error and faults, even when off
// - window at or above reload allows restart anywhere without error
// - interrupt while either unmasked flag set and fault interrupt enabled
// - watchdog reset clears processor, watchdog and both flags
// - reset or status read clears flags, interrupt and fault
// - counter stops in debug or idle when the halt bits ask
// - every processor reset restores register and counter state
// - control write acts only with key 0xA5 in its top byte
// - fault asks processor reset only when proc-only bit set
`timescale 1ns/100ps
module windowed_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int PRESCALE_DIV = PRESCALE
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        slow_clk,
    input  wire logic        dbg_state,
    input  wire logic        sys_idle,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             irq,
    output logic             wd_fault,
    output logic             fault_proc_only
);
    localparam int PRE_W = $clog2(PRESCALE_DIV);
    if (PRESCALE_DIV < 2) begin : g_bad_div
        $error("prescale divider must be at least 2");
    end

    function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // pin synchronisers
    logic [2:0]       slow_s_q;
    logic [1:0]       dbg_s_q;
    logic [1:0]       idle_s_q;
    logic             slow_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_s_q <= 3'h0;
            dbg_s_q  <= 2'h0;
            idle_s_q <= 2'h0;
        end else begin
            slow_s_q <= {slow_s_q[1:0], slow_clk};
            dbg_s_q  <= {dbg_s_q[0], dbg_state};
            idle_s_q <= {idle_s_q[0], sys_idle};
        end
    end

    assign slow_edge = slow_s_q[1] & ~slow_s_q[2];

    // axi write channel
    logic             aw_full_q;
    logic             w_full_q;
    logic             aw_full_d;
    logic             w_full_d;
    logic [7:0]       waddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             awready_q;
    logic             wready_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             wr_go;
    logic             aw_hs;
    logic             w_hs;
    assign aw_hs = awvalid & awready_q;
    assign w_hs  = wvalid & wready_q;
    assign wr_go = aw_full_q & w_full_q & ~bvalid_q;

    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        if (wr_go) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
        end
        if (aw_hs) begin
            aw_full_d = 1'b1;
        end
        if (w_hs) begin
            w_full_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q  <= ~w_full_d;
            if (aw_hs) begin
                waddr_q <= awaddr[7:0];
            end
            if (w_hs) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
        end
    end

    logic             hit_ctrl;
    logic             hit_mode;
    logic             hit_stat;
    logic             hit_mask;
    assign hit_ctrl = waddr_q == CTRL_OFS;
    assign hit_mode = waddr_q == MODE_OFS;
    assign hit_stat = waddr_q == STATUS_OFS;
    assign hit_mask = waddr_q == MASK_OFS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (hit_ctrl | hit_mode | hit_stat | hit_mask) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // register state
    logic [31:0]      mode_q;
    logic             lock_q;
    logic [1:0]       mask_q;
    logic [31:0]      mode_new;
    logic             mode_wr;
    logic             ctrl_wr;
    logic             restart_cmd;
    logic             restart_ok;
    logic             win_err;
    logic [CNT_W-1:0] reload_v;
    logic [CNT_W-1:0] window_v;
    logic [CNT_W-1:0] count_q;
    logic             unf_q;
    logic             err_q;

    assign reload_v = mode_q[RELOAD_LSB +: CNT_W];
    assign window_v = mode_q[WIN_LSB +: CNT_W];
    assign mode_new = wmerge(mode_q, wdata_q, wstrb_q) & MODE_WMASK;
    // one-shot mode write
    assign mode_wr  = wr_go & hit_mode & ~lock_q;
    assign ctrl_wr  = wr_go & hit_ctrl & wstrb_q[3] & wstrb_q[0]
                    & (wdata_q[KEY_LSB +: 8] == KEY_VAL);
    assign restart_cmd = ctrl_wr & wdata_q[RESTART_BIT];
    // window check ignores wd_off on purpose
    assign win_err    = restart_cmd & (count_q > window_v);
    assign restart_ok = restart_cmd & ~win_err;

    // reset defaults: full reload, running, fault reset on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= MODE_RST;
            lock_q <= 1'b0;
        end else if (mode_wr) begin
            mode_q <= mode_new;
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= MASK_RST;
        end else if (wr_go && hit_mask && wstrb_q[0]) begin
            mask_q <= wdata_q[ST_ERR:ST_UNF];
        end
    end

    lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_q && wr_go && hit_mode |=> $stable(mode_q) && lock_q)
        else $error("mode register changed after lock");

    // prescaler and counter
    logic [PRE_W-1:0] pre_q;
    logic             halt;
    logic             tick;
    logic             underflow;
    assign halt = mode_q[OFF_BIT]
                | (mode_q[DBGH_BIT] & dbg_s_q[1])
                | (mode_q[IDLEH_BIT] & idle_s_q[1]);
    assign tick = slow_edge & ~halt & (pre_q == PRE_W'(PRESCALE_DIV - 1));
    assign underflow = tick & (count_q == '0);
    // divide slow clock, restart on reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= '0;
        end else if (mode_wr || restart_ok || tick) begin
            pre_q <= '0;
        end else if (slow_edge && !halt) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // down counter, wraps to reload at underflow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= CNT_RST;
        end else if (mode_wr) begin
            count_q <= mode_new[RELOAD_LSB +: CNT_W];
        end else if (restart_ok || underflow) begin
            count_q <= reload_v;
        end else if (tick) begin
            count_q <= count_q - 1'b1;
        end
    end

    pre_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        slow_edge && !halt && !mode_wr && !restart_ok && !tick
        |=> pre_q == $past(pre_q) + 1'b1)
        else $error("prescaler did not advance on slow edge");
    mode_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_wr |=> count_q == reload_v && pre_q == '0)
        else $error("mode write did not reload counter");
    restart_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        restart_ok |=> count_q == reload_v && pre_q == '0)
        else $error("restart did not reload counter and prescaler");
    bad_key_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && hit_ctrl && wdata_q[KEY_LSB +: 8] != KEY_VAL && !tick
        |=> $stable(count_q) && !$rose(err_q))
        else $error("control write with wrong key had an effect");
    halt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        halt && !mode_wr && !restart_ok |=> $stable(count_q) && !$rose(unf_q))
        else $error("counter moved while halted or off");

    // status flags, fault and interrupt
    logic             fault_q;
    logic             proc_q;
    logic             irq_q;
    logic             stat_rd;

    // flags clear on any reset; a set beats a clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unf_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            if (underflow) begin
                unf_q <= 1'b1;
            end else if (stat_rd) begin
                unf_q <= 1'b0;
            end
            if (win_err) begin
                err_q <= 1'b1;
            end else if (stat_rd) begin
                err_q <= 1'b0;
            end
        end
    end

    // fault to reset controller; proc-only sampled at the fault
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_q <= 1'b0;
            proc_q  <= 1'b0;
        end else if ((underflow && mode_q[FRST_BIT]) || win_err) begin
            fault_q <= 1'b1;
            proc_q  <= mode_q[PROC_BIT];
        end else if (stat_rd) begin
            fault_q <= 1'b0;
            proc_q  <= 1'b0;
        end
    end

    // one cycle behind the flags, so it drops two cycles after the read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= mode_q[FIRQ_BIT] & |({err_q, unf_q} & mask_q);
        end
    end

    unf_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        underflow |=> unf_q
        && (wd_fault == ($past(mode_q[FRST_BIT]) || ($past(fault_q) && !$past(stat_rd)))))
        else $error("underflow flag or fault wrong");
    win_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
        restart_cmd && count_q > window_v |=> err_q && wd_fault && $stable(mode_q))
        else $error("window error not flagged");
    no_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
        restart_cmd && window_v >= reload_v && count_q <= reload_v |=> !$rose(err_q))
        else $error("restart inside full window flagged error");
    irq_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 irq == $past(mode_q[FIRQ_BIT] && ((unf_q && mask_q[ST_UNF]) || (err_q && mask_q[ST_ERR]))))
        else $error("interrupt does not follow flags");
    proc_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(wd_fault) |-> fault_proc_only == $past(mode_q[PROC_BIT]))
        else $error("reset scope does not follow proc-only bit");

    // axi read channel
    logic             arready_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;
    logic             ar_hs;
    logic [7:0]       raddr;
    logic [31:0]      rd_data;
    logic             rd_hit;
    assign ar_hs   = arvalid & arready_q;
    assign raddr   = araddr[7:0];
    // status read clears flags, irq and fault
    assign stat_rd = ar_hs & (raddr == STATUS_OFS);
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (raddr)
            CTRL_OFS:   rd_data = 32'h0000_0000;
            MODE_OFS:   rd_data = mode_q;
            STATUS_OFS: rd_data = {30'h0, err_q, unf_q};
            MASK_OFS:   rd_data = {30'h0, mask_q};
            default:    rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_data;
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    stat_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stat_rd && !underflow && !win_err |=> !unf_q && !err_q && !wd_fault ##1 !irq)
        else $error("status read did not clear flags");
    reset_state_a: assert property (@(posedge aclk)
        !aresetn |=> count_q == CNT_RST && mode_q == MODE_RST && !lock_q
        && !unf_q && !err_q && !wd_fault && !irq)
        else $error("reset did not restore initial state");

    assign awready         = awready_q;
    assign wready          = wready_q;
    assign bvalid          = bvalid_q;
    assign bresp           = bresp_q;
    assign arready         = arready_q;
    assign rvalid          = rvalid_q;
    assign rdata           = rdata_q;
    assign rresp           = rresp_q;
    assign irq             = irq_q;
    assign wd_fault        = fault_q;
    assign fault_proc_only = proc_q;
endmodule : windowed_watchdog_timer

// [dv/wdt_far_side.sv]
// slow clock source and reset controller model for the watchdog bench
`timescale 1ns/100ps
module wdt_far_side #(
    parameter int SLOW_HALF = 20
) (
    input  wire logic aclk,
    input  wire logic honour,
    input  wire logic wd_fault,
    output logic      slow_clk,
    output logic      ctl_rst_n,
    output int        edges
);
    logic fault_q = 1'b0;
    int   hold    = 0;

    // free running, as the real slow oscillator never stops
    initial begin
        slow_clk = 1'b0;
        edges    = 0;
        forever begin
            #(SLOW_HALF) slow_clk = ~slow_clk;
            if (slow_clk) edges++;
        end
    end

    always_ff @(posedge aclk) begin
        fault_q <= wd_fault;
        if (honour && wd_fault && !fault_q) hold <= 6;
        else if (hold > 0) hold <= hold - 1;
    end
    assign ctl_rst_n = (hold == 0);
endmodule : wdt_far_side

// [dv/windowed_watchdog_timer_test.sv]
// self-checking bench for the windowed watchdog timer
`timescale 1ns/100ps
module windowed_watchdog_timer_test;
    import wdt_pkg::*;
    logic        aclk, rst_tb_n, honour, dbg_state, sys_idle, slow_clk, ctl_rst_n;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq, wd_fault, fault_proc_only;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    wire logic   aresetn;
    int          n_errors = 0;
    int          checked  = 0;
    int          edges, e0, n;

    assign aresetn = rst_tb_n & ctl_rst_n;

    windowed_watchdog_timer #(.PRESCALE_DIV(4)) u_windowed_watchdog_timer (
        .aclk(aclk), .aresetn(aresetn), .slow_clk(slow_clk), .dbg_state(dbg_state),
        .sys_idle(sys_idle), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq), .wd_fault(wd_fault), .fault_proc_only(fault_proc_only));

    wdt_far_side u_wdt_far_side (.aclk(aclk), .honour(honour), .wd_fault(wd_fault),
        .slow_clk(slow_clk), .ctl_rst_n(ctl_rst_n), .edges(edges));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge aclk);
        awaddr  <= {24'h0000_00, a};
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= {24'h0000_00, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd  = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rd_reg

    task automatic restart();
        wr(CTRL_OFS, {KEY_VAL, 23'h0, 1'b1});
    endtask : restart

    task automatic do_reset();
        rst_tb_n <= 1'b0;
        cyc(12);
        rst_tb_n <= 1'b1;
        cyc(2);
    endtask : do_reset

    // bounded wait on fault (sel 0) or interrupt (sel 1)
    task automatic wait_hi(input int sel);
        n = 0;
        while (((sel == 0) ? wd_fault : irq) !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_hi

    task automatic test_end(input string name);
        $display("test %s done, errors so far %0d", name, n_errors);
    endtask : test_end

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        cyc(20000);
        n_errors++;
        results();
    end

    initial begin
        rst_tb_n = 1'b0;
        honour = 1'b0;
        dbg_state = 1'b0;
        sys_idle = 1'b0;
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        do_reset();
        rd_reg(MODE_OFS); chk(rd, MODE_RST);
        rd_reg(STATUS_OFS); chk(rd, 32'h0000_0000);
        rd_reg(MASK_OFS); chk(rd, {30'h0, MASK_RST});
        rd_reg(8'h10); chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        restart();
        rd_reg(STATUS_OFS); chk(rd, 32'h0000_0000);
        test_end("defaults");

        wr(MODE_OFS, 32'h0002_7005);
        e0 = edges;
        wr(MODE_OFS, 32'h0000_0FFF);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
        rd_reg(MODE_OFS); chk(rd, 32'h0002_7005);
        wr(CTRL_OFS, 32'h5A00_0001);
        cyc(3); chk({31'h0, wd_fault}, 32'h0);
        restart();
        cyc(3); chk({29'h0, wd_fault, fault_proc_only, irq}, 32'h7);
        rd_reg(STATUS_OFS); chk(rd, 32'h0000_0002);
        cyc(2); chk({30'h0, wd_fault, irq}, 32'h0);
        honour <= 1'b1;
        wait_hi(0);
        chk({31'h0, (edges - e0 >= 23 && edges - e0 <= 25)}, 32'h1);
        chk({31'h0, fault_proc_only}, 32'h1);
        cyc(12);
        honour <= 1'b0;
        rd_reg(MODE_OFS); chk(rd, MODE_RST);
        rd_reg(STATUS_OFS); chk(rd, 32'h0000_0000);
        test_end("window");

        wr(MODE_OFS, 32'h0002_9010);
        restart();
        cyc(3); chk({31'h0, wd_fault}, 32'h1);
        chk({31'h0, fault_proc_only}, 32'h0);
        cyc(800);
        rd_reg(STATUS_OFS); chk(rd, 32'h0000_0002);
        do_reset();
        rd_reg(MODE_OFS); chk(rd, MODE_RST);
        test_end("disabled");

        wr(MODE_OFS, 32'h3FFF_1003);
        repeat (4) begin
            cyc(100);
            restart();
        end
        rd_reg(STATUS_OFS); chk(rd, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            dbg_state <= (i == 0);
            sys_idle  <= (i == 1);
            cyc(4);
            restart();
            cyc(300);
            rd_reg(STATUS_OFS); chk(rd, 32'h0000_0000);
        end
        dbg_state <= 1'b0;
        sys_idle  <= 1'b0;
        // let the halt inputs clear the synchronisers first
        cyc(4);
        restart();
        e0 = edges;
        wait_hi(1);
        chk({31'h0, (edges - e0 >= 15 && edges - e0 <= 17)}, 32'h1);
        chk({31'h0, wd_fault}, 32'h0);
        wr(MASK_OFS, 32'h0000_0000);
        cyc(3); chk({31'h0, irq}, 32'h0);
        wr(MASK_OFS, 32'h0000_0003);
        cyc(3); chk({31'h0, irq}, 32'h1);
        rd_reg(STATUS_OFS); chk(rd, 32'h0000_0001);
        cyc(2); chk({31'h0, irq}, 32'h0);
        test_end("halt_irq");
        results();
    end
endmodule : windowed_watchdog_timer_test
